// >>> rtl/dpwc_consts.vh
`ifndef DPWC_CONSTS_VH
`define DPWC_CONSTS_VH
// ----------------------------------------------------------------
// identity, locations and reset values
// ----------------------------------------------------------------
// identification value is arbitrary
`define DPWC_ID_HI 5'h13
`define DPWC_LOC_WIPER 8'h00
`define DPWC_LOC_ACCESS 8'h02
`define DPWC_ACCESS_VOL 8'h80
`define DPWC_ACCESS_RST 8'h00
`define DPWC_MIDSCALE 7'h40
`define DPWC_STORE_RST 7'h40
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DPWC_CLK_HZ 25000000
`define DPWC_NV_WRITE_MS 20
`define DPWC_NV_WRITE_CYC ((`DPWC_CLK_HZ / 1000) * `DPWC_NV_WRITE_MS)
`define DPWC_POWERUP_US 3000
`define DPWC_POWERUP_CYC ((`DPWC_CLK_HZ / 1000000) * `DPWC_POWERUP_US)
`endif

// >>> rtl/dpwc_top.v
`timescale 1ns/1ns
`default_nettype none
`include "dpwc_consts.vh"
module dpwc_top #(
    parameter [31:0] NV_WRITE_CYC = `DPWC_NV_WRITE_CYC,
    parameter [31:0] POWERUP_CYC = `DPWC_POWERUP_CYC
) (
    input wire core_clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire [1:0] addr_strap_pins,
    output reg [6:0] tap_select,
    output wire nv_busy,
    output wire powerup_busy,
    output wire [7:0] access_select_reg,
    output wire [6:0] power_on_value_store
);
// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
reg [1:0] scl_s_q;
reg [1:0] sda_s_q;
reg [1:0] strap_a_q;
reg [1:0] strap_b_q;
reg scl_d1_q;
reg sda_d1_q;
// two flops per pin, then one history stage on scl and sda for edge finding
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        scl_s_q <= 2'b11;
        sda_s_q <= 2'b11;
        strap_a_q <= 2'b00;
        strap_b_q <= 2'b00;
        scl_d1_q <= 1'b1;
        sda_d1_q <= 1'b1;
    end else begin
        scl_s_q <= {scl_s_q[0], scl_in};
        sda_s_q <= {sda_s_q[0], sda_in};
        strap_a_q <= addr_strap_pins;
        strap_b_q <= strap_a_q;
        scl_d1_q <= scl_s_q[1];
        sda_d1_q <= sda_s_q[1];
    end
end
wire scl = scl_s_q[1];
wire sda = sda_s_q[1];
wire scl_rise = scl & ~scl_d1_q;
wire scl_fall = ~scl & scl_d1_q;
wire start_c = scl & scl_d1_q & sda_d1_q & ~sda;
wire stop_c = scl & scl_d1_q & ~sda_d1_q & sda;
// ----------------------------------------------------------------
// power-up recall and non-volatile write timer
// ----------------------------------------------------------------
reg [31:0] pu_cnt_q;
reg [31:0] nv_cnt_q;
reg [6:0] store_q;
reg [6:0] wiper_q;
reg [7:0] access_q;
reg nv_pend_q;
reg [6:0] nv_data_q;
assign powerup_busy = (pu_cnt_q != 32'h0000_0000);
assign nv_busy = (nv_cnt_q != 32'h0000_0000);
assign access_select_reg = access_q;
assign power_on_value_store = store_q;
wire quiet = powerup_busy | nv_busy;
// ----------------------------------------------------------------
// serial slave state machine
// ----------------------------------------------------------------
localparam [4:0] ST_IDLE = 5'b00001;
localparam [4:0] ST_RX = 5'b00010;
localparam [4:0] ST_ACK = 5'b00100;
localparam [4:0] ST_TX = 5'b01000;
localparam [4:0] ST_MACK = 5'b10000;
reg [4:0] st_q;
reg [3:0] bit_q;
reg [7:0] sh_q;
reg [1:0] byte_q; // 0 ident, 1 location, 2+ data
reg rd_q;
reg [7:0] loc_q;
reg ack_pend_q;
reg wr_nv_q;

// read source per location and access mode
function [7:0] read_val;
    input [7:0] loc;
    input [7:0] acc;
    input [6:0] wip;
    input [6:0] sto;
    begin
        if (loc == `DPWC_LOC_ACCESS)
            read_val = acc;
        else if (loc == `DPWC_LOC_WIPER)
            read_val = {1'b0, (acc == `DPWC_ACCESS_VOL) ? wip : sto};
        else
            read_val = 8'h00;
    end
endfunction

wire [7:0] rx_byte = {sh_q[6:0], sda};
wire id_ok = (rx_byte[7:3] == `DPWC_ID_HI) &&
    (rx_byte[2:1] == strap_b_q);
// byte handed out by a read at the current location
wire [7:0] rd_now = read_val(loc_q, access_q, wiper_q, store_q);

// protocol engine
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        st_q <= ST_IDLE;
        bit_q <= 4'h0;
        sh_q <= 8'h00;
        byte_q <= 2'b00;
        rd_q <= 1'b0;
        loc_q <= 8'h00;
        ack_pend_q <= 1'b0;
        sda_out <= 1'b0;
        sda_oe <= 1'b0;
        wiper_q <= `DPWC_MIDSCALE;
        access_q <= `DPWC_ACCESS_RST;
        store_q <= `DPWC_STORE_RST;
        tap_select <= `DPWC_MIDSCALE;
        pu_cnt_q <= 32'h0000_0001;
        nv_cnt_q <= 32'h0000_0000;
        nv_pend_q <= 1'b0;
        nv_data_q <= 7'h00;
        wr_nv_q <= 1'b0;
    end else begin
        sda_out <= 1'b0;
        tap_select <= wiper_q;
        // power-up: midscale until the recall completes
        if (powerup_busy) begin
            if (pu_cnt_q >= POWERUP_CYC)
                pu_cnt_q <= 32'h0000_0000;
            else
                pu_cnt_q <= pu_cnt_q + 32'h0000_0001;
            if (pu_cnt_q >= POWERUP_CYC)
                wiper_q <= store_q;
        end
        // self-timed write cycle, committed at its end
        if (nv_busy) begin
            if (nv_cnt_q >= NV_WRITE_CYC) begin
                nv_cnt_q <= 32'h0000_0000;
                store_q <= nv_data_q;
            end else begin
                nv_cnt_q <= nv_cnt_q + 32'h0000_0001;
            end
        end
        if (stop_c) begin
            st_q <= ST_IDLE;
            sda_oe <= 1'b0;
            if (nv_pend_q && !quiet)
                nv_cnt_q <= 32'h0000_0001;
            nv_pend_q <= 1'b0;
        end else if (start_c) begin
            sda_oe <= 1'b0;
            if (quiet) begin
                st_q <= ST_IDLE;
            end else begin
                st_q <= ST_RX;
                bit_q <= 4'h0;
                byte_q <= 2'b00;
                nv_pend_q <= 1'b0;
            end
        end else begin
            case (st_q)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        sh_q <= rx_byte;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7) begin
                            ack_pend_q <= 1'b0;
                            if (byte_q == 2'b00) begin
                                rd_q <= sda;
                                ack_pend_q <= id_ok;
                                if (!id_ok)
                                    st_q <= ST_IDLE;
                            end else if (byte_q == 2'b01) begin
                                loc_q <= rx_byte;
                                ack_pend_q <= 1'b1;
                            end else begin
                                ack_pend_q <= 1'b1;
                                if (loc_q == `DPWC_LOC_ACCESS) begin
                                    access_q <= rx_byte;
                                end else if (loc_q == `DPWC_LOC_WIPER) begin
                                    wiper_q <= rx_byte[6:0];
                                    wr_nv_q <= (access_q != `DPWC_ACCESS_VOL);
                                    nv_data_q <= rx_byte[6:0];
                                end
                            end
                        end
                    end else if (scl_fall && bit_q == 4'h8) begin
                        sda_oe <= ack_pend_q;
                        st_q <= ack_pend_q ? ST_ACK : ST_IDLE;
                        if (byte_q == 2'b11 || byte_q == 2'b10)
                            nv_pend_q <= nv_pend_q | wr_nv_q;
                        wr_nv_q <= 1'b0;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_q <= 4'h0;
                        if (byte_q != 2'b11)
                            byte_q <= byte_q + 2'b01;
                        if (rd_q) begin
                            sh_q <= rd_now;
                            sda_oe <= ~rd_now[7];
                            st_q <= ST_TX;
                        end else begin
                            sda_oe <= 1'b0;
                            st_q <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        sh_q <= {sh_q[6:0], 1'b0};
                        if (bit_q == 4'h7) begin
                            sda_oe <= 1'b0;
                            st_q <= ST_MACK;
                        end else begin
                            sda_oe <= ~sh_q[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise)
                        st_q <= sda ? ST_IDLE : ST_ACK;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end
end
endmodule // dpwc_top
`default_nettype wire

// >>> testbench/dpwc_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module dpwc_mon #(
    parameter [31:0] NV_WRITE_CYC = 32'h0000_00c8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [6:0] tap_select,
    input wire logic nv_busy,
    input wire logic powerup_busy,
    input wire logic [6:0] power_on_value_store
);
    logic [31:0] nv_cnt_q;
    // length of the running non-volatile write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_cnt_q <= 32'h0000_0000;
        end else begin
            nv_cnt_q <= nv_busy ? nv_cnt_q + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // protocol and timing checks
    property p_oe_busy;
        (nv_busy || powerup_busy) |-> !sda_oe;
    endproperty
    a_oe_busy: assert property (p_oe_busy)
        else $error("ack when busy");
    property p_od;
        sda_oe |-> !sda_out;
    endproperty
    a_od: assert property (p_od)
        else $error("data driven high");
    property p_tap_busy;
        nv_busy |-> $stable(tap_select);
    endproperty
    a_tap_busy: assert property (p_tap_busy)
        else $error("tap moved");
    property p_store;
        $changed(power_on_value_store) |->
            $past(nv_busy) || $past(nv_busy, 2);
    endproperty
    a_store: assert property (p_store)
        else $error("store moved");
    property p_nv_min;
        $rose(nv_busy) |-> nv_busy[*8];
    endproperty
    a_nv_min: assert property (p_nv_min)
        else $error("write cut short");
    property p_nv_max;
        nv_cnt_q <= NV_WRITE_CYC;
    endproperty
    a_nv_max: assert property (p_nv_max)
        else $error("write too long");
    property p_pu;
        $fell(powerup_busy) |-> ##[1:3] tap_select == power_on_value_store;
    endproperty
    a_pu: assert property (p_pu)
        else $error("no recall");
    property p_oe_scl;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    a_oe_scl: assert property (p_oe_scl)
        else $error("data moved, clock high");
    c_nv: cover property ($rose(nv_busy));
    c_ack: cover property ($rose(sda_oe));
    c_pu: cover property ($fell(powerup_busy));
endmodule // dpwc_mon
bind dpwc_top dpwc_mon #(.NV_WRITE_CYC(NV_WRITE_CYC)) i_dpwc_mon (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .tap_select(tap_select), .nv_busy(nv_busy),
    .powerup_busy(powerup_busy),
    .power_on_value_store(power_on_value_store));
`default_nettype wire

// >>> testbench/dpwc_mst.sv
`timescale 1ns/1ns
`default_nettype none
module dpwc_mst (
    input wire logic core_clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic low_q = 1'b0;
    initial scl = 1'b1;
    // open-drain wire with pull-up
    assign sda = !(low_q || sda_oe);
    task automatic hp();
        repeat (2) @(posedge core_clk);
    endtask
    // data moves only while the clock is low
    task automatic bitx(input logic b, output logic r);
        low_q <= !b;
        hp();
        scl <= 1'b1;
        hp();
        r = sda;
        scl <= 1'b0;
        hp();
    endtask
    task automatic byte_x(input logic [7:0] d, output logic [7:0] q,
        output logic nak);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(1'b1, nak);
    endtask
    task automatic start();
        low_q <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        low_q <= 1'b1;
        hp();
        scl <= 1'b0;
        hp();
    endtask
    // stop, then keep the bus free for over 1300 ns
    task automatic stop();
        low_q <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        low_q <= 1'b0;
        repeat (17) hp();
    endtask
endmodule // dpwc_mst
`default_nettype wire

// >>> testbench/dpwc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "dpwc_consts.vh"
module dpwc_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sda_out, sda_oe, nv_busy, powerup_busy;
    logic [6:0] tap_select;
    logic [6:0] power_on_value_store;
    logic [7:0] access_select_reg;
    logic [1:0] addr_strap_pins = 2'b10;
    wire scl;
    wire sda;
    int bad_count = 0;
    int checks_done = 0;
    // 25 MHz core clock
    always #20 core_clk = !core_clk;
    dpwc_top #(
        .NV_WRITE_CYC(32'h0000_00c8),
        .POWERUP_CYC(32'h0000_0014)
    ) i_dpwc_top (
        .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap_pins(addr_strap_pins),
        .tap_select(tap_select), .nv_busy(nv_busy),
        .powerup_busy(powerup_busy), .access_select_reg(access_select_reg),
        .power_on_value_store(power_on_value_store));
    dpwc_mst i_dpwc_mst (
        .core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic idle();
        for (int i = 0; i < 400 && nv_busy; i++) @(posedge core_clk);
    endtask
    // one data byte to one location; nak bits are id, location, data
    task automatic wr(input logic [1:0] a, input logic [7:0] loc,
        input logic [7:0] d, output logic [2:0] n);
        logic [7:0] q;
        i_dpwc_mst.start();
        i_dpwc_mst.byte_x({`DPWC_ID_HI, a, 1'b0}, q, n[2]);
        i_dpwc_mst.byte_x(loc, q, n[1]);
        i_dpwc_mst.byte_x(d, q, n[0]);
        i_dpwc_mst.stop();
    endtask
    // location phase, repeated start, one byte read with final nak
    task automatic rd(input logic [7:0] loc, output logic [7:0] q);
        logic [2:0] n;
        i_dpwc_mst.start();
        i_dpwc_mst.byte_x({`DPWC_ID_HI, 2'b10, 1'b0}, q, n[2]);
        i_dpwc_mst.byte_x(loc, q, n[1]);
        i_dpwc_mst.start();
        i_dpwc_mst.byte_x({`DPWC_ID_HI, 2'b10, 1'b1}, q, n[0]);
        i_dpwc_mst.byte_x(8'hff, q, n[0]);
        i_dpwc_mst.stop();
    endtask
    // main test sequence
    initial begin
        logic [2:0] n;
        logic [7:0] q;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk({1'b0, tap_select}, 8'h40);
        wr(2'b10, 8'h00, 8'h11, n);
        chk({5'h00, n}, 8'h07);
        chk({1'b0, tap_select}, 8'h40);
        wr(2'b01, 8'h00, 8'h11, n);
        chk({5'h00, n}, 8'h07);
        // move the strap pins and talk to the new address
        addr_strap_pins <= 2'b01;
        repeat (16) @(posedge core_clk);
        wr(2'b01, 8'h02, 8'h00, n);
        chk({5'h00, n}, 8'h00);
        addr_strap_pins <= 2'b10;
        repeat (16) @(posedge core_clk);
        $display("test address filter ended");
        wr(2'b10, 8'h00, 8'hff, n);
        chk({5'h00, n}, 8'h00);
        chk({1'b0, tap_select}, 8'h7f);
        chk({7'h00, nv_busy}, 8'h01);
        wr(2'b10, 8'h00, 8'h11, n);
        chk({5'h00, n}, 8'h07);
        idle();
        chk({1'b0, power_on_value_store}, 8'h7f);
        $display("test non-volatile write ended");
        wr(2'b10, 8'h02, 8'h80, n);
        chk(access_select_reg, 8'h80);
        wr(2'b10, 8'h00, 8'h00, n);
        chk({1'b0, tap_select}, 8'h00);
        chk({7'h00, nv_busy}, 8'h00);
        rd(8'h00, q);
        chk(q, 8'h00);
        wr(2'b10, 8'h02, 8'h00, n);
        rd(8'h00, q);
        chk(q, 8'h7f);
        rd(8'h01, q);
        chk(q, 8'h00);
        $display("test access select ended");
        finish_test();
    end
    // cuts a hung run short
    initial begin
        #800000;
        bad_count++;
        finish_test();
    end
endmodule // dpwc_tb_top
`default_nettype wire
